// file: design/prp_defines.svh
/*
  Constants of the ramp parameter registers: select codes, widths,
  field positions and reset values. Included by the package and core.
*/
`ifndef PRP_DEFINES_SVH
`define PRP_DEFINES_SVH

`define PRP_SEL_ACCEL   4'h3
`define PRP_SEL_MULT    4'h4
`define PRP_SEL_RDP     4'h5
`define PRP_SEL_IDLE    4'h6
`define PRP_SEL_ENV     4'h7

`define PRP_RST_ACCEL   16'h0001
`define PRP_RST_MULT    10'h258
`define PRP_RST_RDP     24'h00_0000
`define PRP_RST_IDLE    3'h0
`define PRP_RST_ENV     24'h00_0000

`define PRP_MULT_SHIFT  13
`define PRP_S_CURVE_MUL 2
`define PRP_ENV_LOW_MSB 15
`define PRP_ENV_BYTE    8

`endif

// file: design/prp_pkg.sv
/*
  Types of the ramp parameter registers: compatibility modes, motion
  states and the layout of the operation environment word.
*/
`include "prp_defines.svh"

package prp_pkg;

  typedef enum logic [1:0] {
    PRP_MODE_NATIVE = 2'h0,
    PRP_MODE_LEG_NEW = 2'h1,
    PRP_MODE_LEG_OLD = 2'h2
  } prp_mode_t;

  typedef enum logic [4:0] {
    PRP_ST_IDLE  = 5'h01,
    PRP_ST_IDLING = 5'h02,
    PRP_ST_ACCEL = 5'h04,
    PRP_ST_CONST = 5'h08,
    PRP_ST_DECEL = 5'h10
  } prp_state_t;

  typedef struct packed {
    logic [7:0] test_space;
    logic       input_port_mode_4;
    logic       input_port_mode_3;
    logic       input_port_mode_2;
    logic       input_port_mode_1;
    logic       io_port_mode;
    logic       interrupt_mask_mode;
    logic       reverse;
    logic       stop_polarity;
    logic       env_bit7;
    logic       env_bit6;
    logic       env_bit5;
    logic       env_bit4;
    logic       auto_ramp_down_select;
    logic       countdown_stop;
    logic       native_mode_enable;
    logic       pulse_output_mode;
  } prp_env_t;

  typedef struct packed {
    logic [15:0] accel_rate;
    logic [9:0]  speed_multiplier;
    logic [23:0] ramp_down_point;
    logic [2:0]  idle_pulse_count;
    prp_env_t    env;
    logic        cmd_count_stop;
    logic [23:0] read_buffer;
    prp_state_t  st;
    logic [12:0] cur_step;
    logic [16:0] ramp_cnt;
    logic [23:0] acc;
    logic [23:0] auto_point;
    logic [23:0] remain;
    logic [2:0]  idle_left;
    logic        pulse;
  } prp_state_s_t;

endpackage

// file: design/prp_regs.sv
/*
  Ramp parameter registers and the pulse generator that applies them.
  Assumes a host that drives the select code with one-cycle write and
  read strobes, and outer logic that supplies speed steps and commands.
*/
`include "prp_defines.svh"
//
// Contract
// - Linear ramp time is step difference times rate
// - S-curve ramp takes twice the linear time
// - Multiplier is ten bits, upper bits read zero
// - Multiplier code 0100b, no readback oldest mode
// - Magnification is clock over multiplier times 8192
// - Pulse rate is speed step times magnification
// - Ramp-down point 24 bits, code 0101b
// - First legacy: upper point byte write only
// - Ramp-down point ignored outside positioning
// - Manual: decelerate when remaining at most point
// - Auto: decelerate at auto value plus correction
// - Auto value cleared, counts up, counts down
// - Positive early then low speed, negative late
// - Condition at start: low speed, no ramp
// - Idle count three bits, code 0110b
// - Idle pulses precede acceleration on fast start
// - Environment 24 bits, upper byte write only
// - First legacy: environment middle byte write only
// - Environment bit layout from bit zero upward
// - Rate register sixteen bits read and write
// - Rate register loaded with nonzero values
// - Remaining count decrements, stops at zero
module prp_regs
  import prp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire prp_mode_t   compat_mode,
  input  wire logic [3:0]  register_select_code,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  input  wire logic [23:0] write_buffer,
  output logic      [23:0] read_buffer,
  input  wire logic [12:0] low_speed_step,
  input  wire logic [12:0] high_speed_step,
  input  wire logic        count_load,
  input  wire logic [23:0] pulse_count_target,
  input  wire logic        positioning_mode_bit,
  input  wire logic        s_curve,
  input  wire logic        start_req,
  input  wire logic        high_speed_start,
  input  wire logic        decel_stop_req,
  input  wire logic        stop_req,
  output logic             pulse_out,
  output logic             busy,
  output logic      [12:0] speed_step,
  output logic      [23:0] remaining_pulse_count,
  output prp_env_t         operation_environment
);

  prp_state_s_t q_r;
  prp_state_s_t q_nxt;

  logic [3:0]  eff_code;
  logic        native;
  logic        count_stop;
  logic [22:0] period;
  logic [24:0] acc_sum;
  logic        fire;
  logic signed [25:0] auto_sum;
  logic        decel_cond;
  logic [16:0] ramp_limit;
  logic        ramp_tick;
  logic        last_pulse;

  assign native = (compat_mode == PRP_MODE_NATIVE);
  assign eff_code = native ? register_select_code
                           : {1'b0, register_select_code[2:0]};
  assign count_stop = native ? q_r.env.countdown_stop : q_r.cmd_count_stop;

  assign period = {q_r.speed_multiplier, 13'h0000};
  assign acc_sum = {1'b0, q_r.acc} + {12'h000, q_r.cur_step};
  assign fire = (q_r.st != PRP_ST_IDLE) && (acc_sum >= {2'b00, period});

  assign auto_sum = $signed({2'b00, q_r.auto_point})
                  + $signed({{2{q_r.ramp_down_point[23]}},
                             q_r.ramp_down_point});

  always_comb begin
    decel_cond = 1'b0;
    if (positioning_mode_bit) begin
      if (q_r.env.auto_ramp_down_select) begin
        decel_cond = ($signed({2'b00, q_r.remain}) <= auto_sum);
      end else begin
        decel_cond = (q_r.remain <= q_r.ramp_down_point);
      end
    end
  end

  assign ramp_limit = s_curve ? {q_r.accel_rate, 1'b0}
                              : {1'b0, q_r.accel_rate};
  assign ramp_tick = ((q_r.ramp_cnt + 17'h0_0001) >= ramp_limit);

  assign last_pulse = positioning_mode_bit && !count_stop
                    && (q_r.remain == 24'h00_0001);

  always_comb begin
    q_nxt = q_r;
    q_nxt.pulse = 1'b0;

    if (wr_stb || rd_stb) begin
      q_nxt.cmd_count_stop = register_select_code[3];
    end

    if (wr_stb) begin
      unique case (eff_code)
        `PRP_SEL_ACCEL: q_nxt.accel_rate = write_buffer[15:0];
        `PRP_SEL_MULT:  q_nxt.speed_multiplier = write_buffer[9:0];
        `PRP_SEL_RDP:   q_nxt.ramp_down_point = write_buffer;
        `PRP_SEL_IDLE:  q_nxt.idle_pulse_count = write_buffer[2:0];
        `PRP_SEL_ENV:   q_nxt.env = write_buffer;
        default: ;
      endcase
    end

    if (rd_stb) begin
      q_nxt.read_buffer = 24'h00_0000;
      if (compat_mode != PRP_MODE_LEG_OLD) begin
        unique case (eff_code)
          `PRP_SEL_ACCEL: q_nxt.read_buffer = {8'h00, q_r.accel_rate};
          `PRP_SEL_MULT:  q_nxt.read_buffer = {14'h0000, q_r.speed_multiplier};
          `PRP_SEL_RDP: begin
            if (native) begin
              q_nxt.read_buffer = q_r.ramp_down_point;
            end else begin
              q_nxt.read_buffer = {8'h00, q_r.ramp_down_point[15:0]};
            end
          end
          `PRP_SEL_IDLE:  q_nxt.read_buffer = {21'h00_0000, q_r.idle_pulse_count};
          `PRP_SEL_ENV: begin
            if (native) begin
              q_nxt.read_buffer = {8'h00, q_r.env[15:0]};
            end else begin
              q_nxt.read_buffer = {16'h0000, q_r.env[7:0]};
            end
          end
          default: ;
        endcase
      end
    end

    if (count_load) begin
      q_nxt.remain = pulse_count_target;
    end

    if (fire) begin
      q_nxt.acc = 24'(acc_sum - {2'b00, period});
      q_nxt.pulse = 1'b1;
      if (!count_stop && (q_r.remain != 24'h00_0000)) begin
        q_nxt.remain = q_r.remain - 24'h00_0001;
      end
      if (q_r.st == PRP_ST_ACCEL) begin
        q_nxt.auto_point = q_r.auto_point + 24'h00_0001;
      end else if ((q_r.st == PRP_ST_DECEL) && (q_r.auto_point != 24'h00_0000)) begin
        q_nxt.auto_point = q_r.auto_point - 24'h00_0001;
      end
    end else if (q_r.st != PRP_ST_IDLE) begin
      q_nxt.acc = acc_sum[23:0];
    end

    unique case (q_r.st)
      PRP_ST_IDLE: begin
        if (start_req) begin
          q_nxt.auto_point = 24'h00_0000;
          q_nxt.acc = 24'h00_0000;
          q_nxt.ramp_cnt = 17'h0_0000;
          q_nxt.cur_step = low_speed_step;
          if (positioning_mode_bit && (q_r.remain == 24'h00_0000)) begin
            q_nxt.st = PRP_ST_IDLE;
          end else if (!high_speed_start || decel_cond) begin
            q_nxt.st = PRP_ST_CONST;
          end else if (q_r.idle_pulse_count != 3'h0) begin
            q_nxt.idle_left = q_r.idle_pulse_count;
            q_nxt.st = PRP_ST_IDLING;
          end else begin
            q_nxt.st = PRP_ST_ACCEL;
          end
        end
      end
      PRP_ST_IDLING: begin
        if (fire) begin
          q_nxt.idle_left = q_r.idle_left - 3'h1;
          if (q_r.idle_left == 3'h1) begin
            q_nxt.st = PRP_ST_ACCEL;
          end
        end
      end
      PRP_ST_ACCEL: begin
        if (decel_cond || decel_stop_req) begin
          q_nxt.ramp_cnt = 17'h0_0000;
          q_nxt.st = PRP_ST_DECEL;
        end else if (q_r.cur_step >= high_speed_step) begin
          q_nxt.cur_step = high_speed_step;
          q_nxt.st = PRP_ST_CONST;
        end else if (ramp_tick) begin
          q_nxt.ramp_cnt = 17'h0_0000;
          q_nxt.cur_step = q_r.cur_step + 13'h0001;
        end else begin
          q_nxt.ramp_cnt = q_r.ramp_cnt + 17'h0_0001;
        end
      end
      PRP_ST_CONST: begin
        if (q_r.cur_step > low_speed_step) begin
          if (decel_cond || decel_stop_req) begin
            q_nxt.ramp_cnt = 17'h0_0000;
            q_nxt.st = PRP_ST_DECEL;
          end
        end else if (decel_stop_req && !positioning_mode_bit) begin
          q_nxt.st = PRP_ST_IDLE;
        end
      end
      PRP_ST_DECEL: begin
        if (q_r.cur_step <= low_speed_step) begin
          q_nxt.cur_step = low_speed_step;
          if (!positioning_mode_bit) begin
            q_nxt.st = PRP_ST_IDLE;
          end else begin
            q_nxt.st = PRP_ST_CONST;
          end
        end else if (ramp_tick) begin
          q_nxt.ramp_cnt = 17'h0_0000;
          q_nxt.cur_step = q_r.cur_step - 13'h0001;
        end else begin
          q_nxt.ramp_cnt = q_r.ramp_cnt + 17'h0_0001;
        end
      end
      default: begin
        q_nxt.st = PRP_ST_IDLE;
      end
    endcase

    // late point stops above low speed
    if (fire && last_pulse && (q_r.st != PRP_ST_IDLE)) begin
      q_nxt.st = PRP_ST_IDLE;
    end
    if (stop_req) begin
      q_nxt.st = PRP_ST_IDLE;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q_r <= '0;
      q_r.accel_rate <= `PRP_RST_ACCEL;
      q_r.speed_multiplier <= `PRP_RST_MULT;
      q_r.ramp_down_point <= `PRP_RST_RDP;
      q_r.idle_pulse_count <= `PRP_RST_IDLE;
      q_r.env <= `PRP_RST_ENV;
      q_r.st <= PRP_ST_IDLE;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign read_buffer = q_r.read_buffer;
  assign pulse_out = q_r.pulse;
  assign busy = (q_r.st != PRP_ST_IDLE);
  assign speed_step = q_r.cur_step;
  assign remaining_pulse_count = q_r.remain;
  assign operation_environment = q_r.env;

endmodule // prp_regs

// file: test/prp_host.sv
/*
  Host model that writes and reads the ramp registers by select code.
  Assumes one-cycle strobes that the block samples on the rising edge.
*/
module prp_host (
  input  wire logic        clock,
  output logic      [3:0]  register_select_code,
  output logic             wr_stb,
  output logic             rd_stb,
  output logic      [23:0] write_buffer,
  input  wire logic [23:0] read_buffer
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    register_select_code = 4'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    write_buffer = 24'h00_0000;
  end
  task automatic wr(input logic [3:0] code, input logic [23:0] data);
    @(posedge clock);
    register_select_code <= code;
    write_buffer <= data;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    write_buffer <= ~data;
    register_select_code <= ~code;
  endtask
  task automatic rd(input logic [3:0] code, output logic [23:0] data);
    @(posedge clock);
    register_select_code <= code;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    register_select_code <= ~code;
    @(negedge clock);
    data = read_buffer;
  endtask
endmodule // prp_host

// file: test/prp_regs_asserts.sv
/*
  Checker of the ramp parameter registers.
  Bound to prp_regs and sees only its ports.
*/
module prp_regs_asserts
  import prp_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire prp_mode_t   compat_mode,
  input wire logic [3:0]  register_select_code,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [23:0] write_buffer,
  input wire logic [23:0] read_buffer,
  input wire logic        count_load,
  input wire logic        positioning_mode_bit,
  input wire logic        start_req,
  input wire logic        pulse_out,
  input wire logic        busy,
  input wire logic [23:0] remaining_pulse_count,
  input wire prp_env_t    operation_environment
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire nat = compat_mode == PRP_MODE_NATIVE;
  wire cnt = nat && !operation_environment.countdown_stop;
  wire [2:0] sel = register_select_code[2:0];
  a_mult_upper: assert property (rd_stb && sel == 3'h4 |=> read_buffer[23:10] == 14'h0)
    else $error("multiplier upper bits set");
  a_idle_upper: assert property (rd_stb && sel == 3'h6 |=> read_buffer[23:3] == 21'h0)
    else $error("idle count upper bits set");
  a_rate_upper: assert property (rd_stb && sel == 3'h3 |=> read_buffer[23:16] == 8'h00)
    else $error("rate upper bits set");
  a_old_noread: assert property (rd_stb && compat_mode == PRP_MODE_LEG_OLD
    |=> read_buffer == 24'h00_0000) else $error("oldest mode read data");
  a_point_legacy: assert property (rd_stb && compat_mode == PRP_MODE_LEG_NEW
    && sel == 3'h5 |=> read_buffer[23:16] == 8'h00)
    else $error("legacy point upper byte read");
  a_env_legacy: assert property (rd_stb && !nat && sel == 3'h7
    |=> read_buffer[23:8] == 16'h0) else $error("legacy env upper bytes read");
  a_env_write: assert property (wr_stb && nat && register_select_code == 4'h7
    |=> operation_environment == $past(write_buffer)) else $error("env not written");
  a_pulse_one: assert property (pulse_out |=> !pulse_out) else $error("pulse too long");
  a_count_down: assert property (pulse_out && cnt && $past(remaining_pulse_count) != 24'h0
    && !$past(count_load) |-> remaining_pulse_count == $past(remaining_pulse_count) - 24'h1)
    else $error("remaining count not decremented");
  a_zero_stop: assert property (pulse_out && cnt && positioning_mode_bit
    && remaining_pulse_count == 24'h0 |-> !busy) else $error("no stop at zero");
  cover property (pulse_out && positioning_mode_bit);
  cover property (rd_stb && compat_mode == PRP_MODE_LEG_NEW);
  cover property (start_req && !busy ##1 busy);
endmodule // prp_regs_asserts

bind prp_regs prp_regs_asserts u_asserts (
  .clock(clock), .rst(rst), .compat_mode(compat_mode),
  .register_select_code(register_select_code), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .write_buffer(write_buffer), .read_buffer(read_buffer), .count_load(count_load),
  .positioning_mode_bit(positioning_mode_bit), .start_req(start_req),
  .pulse_out(pulse_out), .busy(busy), .remaining_pulse_count(remaining_pulse_count),
  .operation_environment(operation_environment)
);

// file: test/testbench.sv
/*
  Testbench of the ramp parameter registers.
  Drives prp_regs through the host model and checks its ports.
*/
module testbench
  import prp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  prp_mode_t   compat_mode = PRP_MODE_NATIVE;
  logic [3:0]  register_select_code;
  logic        wr_stb, rd_stb, pulse_out, busy;
  logic [23:0] write_buffer, read_buffer, remaining_pulse_count, rd_data;
  logic [23:0] pulse_count_target = 24'h00_0000;
  logic [12:0] low_speed_step = 13'h0064;
  logic [12:0] high_speed_step = 13'h006E;
  logic [12:0] speed_step, max_step;
  logic        count_load = 1'b0;
  logic        positioning_mode_bit = 1'b0;
  logic        s_curve = 1'b0;
  logic        start_req = 1'b0;
  logic        high_speed_start = 1'b0;
  logic        stop_req = 1'b0;
  prp_env_t    operation_environment;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          n_pls, n_low, t_high, t_first, t_last, exp_t;
  logic [23:0] wv [5] = '{24'h00_ABCD, 24'h00_03FF, 24'h12_3456, 24'h00_0005, 24'h00_A5C3};
  logic [23:0] rv [5] = '{24'h00_0001, 24'h00_0258, 24'h00_0000, 24'h00_0000, 24'h00_0000};

  prp_host u_host (.clock(clock), .register_select_code(register_select_code),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .write_buffer(write_buffer), .read_buffer(read_buffer));
  prp_regs dut (.clock(clock), .rst(rst), .compat_mode(compat_mode),
    .register_select_code(register_select_code), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .write_buffer(write_buffer), .read_buffer(read_buffer), .low_speed_step(low_speed_step),
    .high_speed_step(high_speed_step), .count_load(count_load),
    .pulse_count_target(pulse_count_target), .positioning_mode_bit(positioning_mode_bit),
    .s_curve(s_curve), .start_req(start_req), .high_speed_start(high_speed_start),
    .decel_stop_req(1'b0), .stop_req(stop_req), .pulse_out(pulse_out), .busy(busy),
    .speed_step(speed_step), .remaining_pulse_count(remaining_pulse_count),
    .operation_environment(operation_environment));

  initial forever #4 clock = ~clock;

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  // Loads the counter, starts, records pulses and steps, then stops
  task automatic run(input logic posi, input logic hs, input int lim);
    n_pls = 0;
    n_low = 0;
    t_high = -1;
    max_step = 13'h0000;
    @(posedge clock);
    positioning_mode_bit <= posi;
    high_speed_start <= hs;
    count_load <= 1'b1;
    @(posedge clock);
    count_load <= 1'b0;
    start_req <= 1'b1;
    @(posedge clock);
    start_req <= 1'b0;
    for (int t = 0; t < lim && (t < 3 || busy === 1'b1); t++) begin
      @(negedge clock);
      if (pulse_out === 1'b1) begin
        if (n_pls == 0) t_first = t;
        t_last = t;
        n_pls++;
        if (max_step <= low_speed_step) n_low++;
      end
      if (speed_step > max_step) max_step = speed_step;
      if (speed_step === high_speed_step && t_high < 0) t_high = t;
    end
    @(posedge clock);
    stop_req <= 1'b1;
    @(posedge clock);
    stop_req <= 1'b0;
  endtask

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      u_host.rd(4'(i + 3), rd_data);
      check("reset value", rd_data, rv[i]);
    end
    for (int i = 0; i < 5; i++) u_host.wr(4'(i + 3), wv[i]);
    for (int i = 0; i < 5; i++) begin
      u_host.rd(4'(i + 3), rd_data);
      check("native readback", rd_data, wv[i]);
    end
    check("env word", operation_environment, 24'h00_A5C3);
    check("env bit 15", 24'(operation_environment.input_port_mode_4), 24'h1);
    u_host.wr(4'h9, 24'hFF_FFFF);
    u_host.rd(4'h9, rd_data);
    check("unmapped read", rd_data, 24'h00_0000);
    u_host.rd(4'h4, rd_data);
    check("multiplier kept", rd_data, 24'h00_03FF);
    @(posedge clock);
    compat_mode <= PRP_MODE_LEG_NEW;
    u_host.rd(4'h5, rd_data);
    check("legacy point", rd_data, 24'h00_3456);
    u_host.rd(4'h7, rd_data);
    check("legacy env", rd_data, 24'h00_00C3);
    @(posedge clock);
    compat_mode <= PRP_MODE_LEG_OLD;
    u_host.rd(4'h3, rd_data);
    check("oldest read", rd_data, 24'h00_0000);
    @(posedge clock);
    compat_mode <= PRP_MODE_NATIVE;
    u_host.wr(4'h7, 24'h00_0000);
    u_host.wr(4'h4, 24'h00_0002);
    u_host.wr(4'h3, 24'h00_0014);
    u_host.wr(4'h5, 24'hFF_FFFF);
    u_host.wr(4'h6, 24'h00_0000);
    $display("test registers done");
    pulse_count_target <= 24'h00_FFFF;
    for (int s = 0; s < 2; s++) begin
      s_curve <= s[0];
      run(1'b0, 1'b1, 600);
      exp_t = 10 * 20 * (s + 1);
      check("ramp time", 24'(t_high > exp_t - 4 && t_high < exp_t + 4), 24'h1);
    end
    low_speed_step <= 13'h1000;
    for (int m = 2; m < 5; m += 2) begin
      u_host.wr(4'h4, 24'(m));
      pulse_count_target <= 24'h00_0014;
      run(1'b1, 1'b0, 400);
      check("pulse count", 24'(n_pls), 24'h00_0014);
      check("pulse period", 24'(t_last - t_first), 24'(19 * m * 8192 / 4096));
      check("remaining zero", remaining_pulse_count, 24'h00_0000);
    end
    u_host.wr(4'h4, 24'h00_0002);
    low_speed_step <= 13'h0064;
    pulse_count_target <= 24'h00_0005;
    run(1'b1, 1'b1, 2000);
    check("no ramp at start", 24'(max_step), 24'h00_0064);
    check("start pulse count", 24'(n_pls), 24'h00_0005);
    u_host.wr(4'h3, 24'h00_0001);
    pulse_count_target <= 24'h00_FFFF;
    for (int k = 0; k < 4; k += 3) begin
      u_host.wr(4'h6, 24'(k));
      run(1'b0, 1'b1, 800);
      check("idle pulses", 24'(n_low), 24'(k));
    end
    u_host.wr(4'h7, 24'h00_0008);
    u_host.wr(4'h5, 24'h00_0005);
    pulse_count_target <= 24'h00_000A;
    run(1'b1, 1'b1, 3000);
    check("auto ramp peak", 24'(max_step), 24'h00_006E);
    check("auto pulse count", 24'(n_pls), 24'h00_000A);
    check("ends at low speed", 24'(speed_step), 24'h00_0064);
    $display("test motion done");
    complete_run();
  end
endmodule // testbench
